// ===== inc/fpp_pkg.sv
// constants, types and register map of the flash page programmer
//
// How it works
// - pages and buffer hold 128 16-bit words
// - erase page, write buffer, read one word
// - enabled status set only by enable procedure
// - buffer loads only while enabled status high
// - write start bit held until write done
// - read needs enable; start bit cleared when fetched
// - erase page from high byte and bit7
// - buffer clear bit self-clears after clearing
// - address 15:7 page, 6:0 buffer index
// - high data write loads whole word
// - high data write while enabled increments address bits 6:0
// - address sticks at last word of page
// - buffer cleared after every page write
// - mode codes 000 001 011 110
// - software may only clear enabled status
// - processor stalled while operation runs
package fpp_pkg;

    localparam int unsigned PAGE_WORDS = 128;
    localparam int unsigned IDX_W      = 7;
    localparam int unsigned WORD_W     = 16;
    localparam int unsigned REG_AW     = 4;

    localparam logic [IDX_W-1:0]  LAST_IDX   = 7'h7f;
    localparam logic [IDX_W-1:0]  FIRST_IDX  = 7'h00;
    localparam logic [7:0]        MAX_PAGE_HI = 8'hbf;
    localparam logic [WORD_W-1:0] BUF_CLEAR_VALUE = 16'h0000;

    // register offsets
    localparam logic [REG_AW-1:0] OFS_CTRL   = 4'h0;
    localparam logic [REG_AW-1:0] OFS_BUFCTL = 4'h2;
    localparam logic [REG_AW-1:0] OFS_ADDRL  = 4'h3;
    localparam logic [REG_AW-1:0] OFS_ADDRH  = 4'h4;
    localparam logic [REG_AW-1:0] OFS_DATAL  = 4'h5;
    localparam logic [REG_AW-1:0] OFS_DATAH  = 4'h6;
    localparam logic [REG_AW-1:0] OFS_KEY1L  = 4'h7;
    localparam logic [REG_AW-1:0] OFS_KEY1H  = 4'h8;
    localparam logic [REG_AW-1:0] OFS_KEY2L  = 4'h9;
    localparam logic [REG_AW-1:0] OFS_KEY2H  = 4'ha;
    localparam logic [REG_AW-1:0] OFS_KEY3L  = 4'hb;
    localparam logic [REG_AW-1:0] OFS_KEY3H  = 4'hc;

    // control register bit positions
    localparam int unsigned BIT_ENABLED  = 7;
    localparam int unsigned BIT_MODE_HI  = 6;
    localparam int unsigned BIT_MODE_LO  = 4;
    localparam int unsigned BIT_TRIGGER  = 3;
    localparam int unsigned BIT_WSTART   = 2;
    localparam int unsigned BIT_RDEN     = 1;
    localparam int unsigned BIT_RSTART   = 0;
    localparam int unsigned BIT_BUFCLEAR = 0;

    // enable procedure key words; values are arbitrary
    localparam logic [WORD_W-1:0] KEY1_VALUE = 16'h1234;
    localparam logic [WORD_W-1:0] KEY2_VALUE = 16'h5678;
    localparam logic [WORD_W-1:0] KEY3_VALUE = 16'h9abc;

    // window in which the key words must arrive after the trigger
    localparam int unsigned CLK_PERIOD_NS    = 25;
    localparam int unsigned KEY_WINDOW_NS    = 100000;
    localparam int unsigned KEY_WINDOW_CYC   = KEY_WINDOW_NS / CLK_PERIOD_NS;
    localparam int unsigned TIMER_W          = 12;

    typedef enum logic [2:0] {
        MODE_WRITE  = 3'h0,
        MODE_ERASE  = 3'h1,
        MODE_READ   = 3'h3,
        MODE_ENABLE = 3'h6
    } fpp_mode_type;

    typedef enum logic [1:0] {
        CMD_WRITE_WORD = 2'h0,
        CMD_ERASE_PAGE = 2'h1,
        CMD_READ_WORD  = 2'h2
    } fpp_cmd_type;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_WRITE = 5'b00010,
        ST_ERASE = 5'b00100,
        ST_READ  = 5'b01000,
        ST_CLEAR = 5'b10000
    } fpp_state_type;

    typedef struct packed {
        logic               req;
        fpp_cmd_type        cmd;
        logic [WORD_W-1:0]  addr;
        logic [WORD_W-1:0]  wdata;
    } fpp_flash_req_type;

endpackage

// ===== design/fpp_write_buffer.sv
// page write buffer: 128 words of flops, one load port, one-cycle clear
`timescale 1ns/1ps
`default_nettype none
module fpp_write_buffer (
    input  wire logic                          clk_sys,
    input  wire logic                          reset,
    input  wire logic                          loadEn,
    input  wire logic [fpp_pkg::IDX_W-1:0]     loadIdx,
    input  wire logic [fpp_pkg::WORD_W-1:0]    loadWord,
    input  wire logic                          clearAll,
    input  wire logic [fpp_pkg::IDX_W-1:0]     readIdx,
    output logic      [fpp_pkg::WORD_W-1:0]    readWord
);

    logic [fpp_pkg::WORD_W-1:0] mem_q [fpp_pkg::PAGE_WORDS];

    // clear wins over a load in the same cycle
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < fpp_pkg::PAGE_WORDS; i++) begin
                mem_q[i] <= fpp_pkg::BUF_CLEAR_VALUE;
            end
        end else if (clearAll) begin
            for (int i = 0; i < fpp_pkg::PAGE_WORDS; i++) begin
                mem_q[i] <= fpp_pkg::BUF_CLEAR_VALUE;
            end
        end else if (loadEn) begin
            mem_q[loadIdx] <= loadWord;
        end
    end

    assign readWord = mem_q[readIdx];

endmodule
`default_nettype wire

// ===== design/fpp_page_programmer.sv
// flash page programmer: register port, enable procedure and operation sequencer
`timescale 1ns/1ps
`default_nettype none
module fpp_page_programmer (
    input  wire logic                               clk_sys,
    input  wire logic                               reset,
    // register port
    input  wire logic [fpp_pkg::REG_AW-1:0]         regAddr,
    input  wire logic [7:0]                         regWdata,
    input  wire logic                               regWrite,
    input  wire logic                               regRead,
    output logic      [7:0]                         regRdata,
    // processor hold
    output logic                                    cpuStall,
    // flash array port
    output fpp_pkg::fpp_flash_req_type              flashReq,
    input  wire logic                               flashAck,
    input  wire logic [fpp_pkg::WORD_W-1:0]         flashRdata
);

    ////////////////////////////////////////////////////////////////////////////
    // register state

    logic                            enabled_q;
    logic [2:0]                      mode_q;
    logic                            trigger_q;
    logic                            wstart_q;
    logic                            rden_q;
    logic                            rstart_q;
    logic                            bufClear_q;
    logic [fpp_pkg::WORD_W-1:0]      addr_q;
    logic [7:0]                      dataLow_q;
    logic [7:0]                      dataHigh_q;
    logic [fpp_pkg::WORD_W-1:0]      key1_q;
    logic [fpp_pkg::WORD_W-1:0]      key2_q;
    logic [7:0]                      key3Low_q;
    logic [fpp_pkg::TIMER_W-1:0]     timer_q;
    logic [7:0]                      regRdata_q;
    fpp_pkg::fpp_state_type          state_q;
    logic [fpp_pkg::IDX_W-1:0]       idx_q;

    logic                            wrCtrl;
    logic                            wrBufCtl;
    logic                            wrDataHigh;
    logic                            wrKey3High;
    logic                            pageValid;
    logic                            keyMatch;
    logic                            keyTimeout;
    logic                            loadBuf;
    logic                            opDone;
    logic                            clearBuf;
    logic [fpp_pkg::WORD_W-1:0]      bufWord;
    logic [fpp_pkg::WORD_W-1:0]      pageBase;

    assign wrCtrl     = regWrite && (regAddr == fpp_pkg::OFS_CTRL);
    assign wrBufCtl   = regWrite && (regAddr == fpp_pkg::OFS_BUFCTL);
    assign wrDataHigh = regWrite && (regAddr == fpp_pkg::OFS_DATAH);
    assign wrKey3High = regWrite && (regAddr == fpp_pkg::OFS_KEY3H);

    // highest legal page is high byte bf with bit 7 of the low byte set
    assign pageValid  = (addr_q[15:8] <= fpp_pkg::MAX_PAGE_HI);
    assign pageBase   = {addr_q[15:7], fpp_pkg::FIRST_IDX};
    assign keyMatch   = trigger_q && (mode_q == fpp_pkg::MODE_ENABLE) && wrKey3High
                        && (key1_q == fpp_pkg::KEY1_VALUE) && (key2_q == fpp_pkg::KEY2_VALUE)
                        && ({regWdata, key3Low_q} == fpp_pkg::KEY3_VALUE);
    assign keyTimeout = trigger_q
                        && (timer_q == fpp_pkg::TIMER_W'(fpp_pkg::KEY_WINDOW_CYC - 1));
    assign loadBuf    = wrDataHigh && enabled_q;

    ////////////////////////////////////////////////////////////////////////////
    // enable procedure

    // status set by a matching key sequence wins over a software clear
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            enabled_q <= 1'b0;
        end else if (keyMatch) begin
            enabled_q <= 1'b1;
        end else if (wrCtrl && !regWdata[fpp_pkg::BIT_ENABLED]) begin
            enabled_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            trigger_q <= 1'b0;
            timer_q   <= '0;
        end else if (keyMatch || keyTimeout) begin
            trigger_q <= 1'b0;
            timer_q   <= '0;
        end else if (wrCtrl && regWdata[fpp_pkg::BIT_TRIGGER]) begin
            trigger_q <= 1'b1;
            timer_q   <= '0;
        end else if (trigger_q) begin
            timer_q   <= timer_q + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            key1_q    <= '0;
            key2_q    <= '0;
            key3Low_q <= '0;
        end else if (regWrite) begin
            unique case (regAddr)
                fpp_pkg::OFS_KEY1L: key1_q[7:0]  <= regWdata;
                fpp_pkg::OFS_KEY1H: key1_q[15:8] <= regWdata;
                fpp_pkg::OFS_KEY2L: key2_q[7:0]  <= regWdata;
                fpp_pkg::OFS_KEY2H: key2_q[15:8] <= regWdata;
                fpp_pkg::OFS_KEY3L: key3Low_q    <= regWdata;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mode, enables and start bits

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            mode_q <= fpp_pkg::MODE_WRITE;
            rden_q <= 1'b0;
        end else if (wrCtrl) begin
            mode_q <= regWdata[fpp_pkg::BIT_MODE_HI:fpp_pkg::BIT_MODE_LO];
            rden_q <= regWdata[fpp_pkg::BIT_RDEN];
        end
    end

    // a start only takes when the operation is legal, so a refused start reads back 0
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wstart_q <= 1'b0;
        end else if (opDone && (state_q != fpp_pkg::ST_READ)) begin
            wstart_q <= 1'b0;
        end else if (wrCtrl && regWdata[fpp_pkg::BIT_WSTART] && enabled_q && pageValid
                     && (regWdata[fpp_pkg::BIT_MODE_HI:fpp_pkg::BIT_MODE_LO] == fpp_pkg::MODE_WRITE
                      || regWdata[fpp_pkg::BIT_MODE_HI:fpp_pkg::BIT_MODE_LO] == fpp_pkg::MODE_ERASE)) begin
            wstart_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rstart_q <= 1'b0;
        end else if (opDone && (state_q == fpp_pkg::ST_READ)) begin
            rstart_q <= 1'b0;
        end else if (wrCtrl && regWdata[fpp_pkg::BIT_RSTART] && regWdata[fpp_pkg::BIT_RDEN]
                     && (regWdata[fpp_pkg::BIT_MODE_HI:fpp_pkg::BIT_MODE_LO] == fpp_pkg::MODE_READ)) begin
            rstart_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            bufClear_q <= 1'b0;
        end else if (wrBufCtl && regWdata[fpp_pkg::BIT_BUFCLEAR]) begin
            // a request in the clearing cycle is kept, not lost
            bufClear_q <= 1'b1;
        end else if (state_q == fpp_pkg::ST_CLEAR) begin
            bufClear_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // address and data registers

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            addr_q <= '0;
        end else if (regWrite && (regAddr == fpp_pkg::OFS_ADDRL)) begin
            addr_q[7:0] <= regWdata;
        end else if (regWrite && (regAddr == fpp_pkg::OFS_ADDRH)) begin
            addr_q[15:8] <= regWdata;
        end else if (loadBuf && (addr_q[6:0] != fpp_pkg::LAST_IDX)) begin
            addr_q[6:0] <= addr_q[6:0] + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            dataLow_q  <= '0;
            dataHigh_q <= '0;
        end else if (opDone && (state_q == fpp_pkg::ST_READ)) begin
            dataLow_q  <= flashRdata[7:0];
            dataHigh_q <= flashRdata[15:8];
        end else if (regWrite && (regAddr == fpp_pkg::OFS_DATAL)) begin
            dataLow_q  <= regWdata;
        end else if (wrDataHigh) begin
            dataHigh_q <= regWdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // write buffer

    // cleared after each page write and on request, never by an erase
    assign clearBuf = (state_q == fpp_pkg::ST_CLEAR)
                      || (opDone && (state_q == fpp_pkg::ST_WRITE));

    fpp_write_buffer u_buffer (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .loadEn   (loadBuf),
        .loadIdx  (addr_q[6:0]),
        .loadWord ({regWdata, dataLow_q}),
        .clearAll (clearBuf),
        .readIdx  (idx_q),
        .readWord (bufWord)
    );

    ////////////////////////////////////////////////////////////////////////////
    // operation sequencer

    assign opDone = flashAck && (
                      (state_q == fpp_pkg::ST_WRITE && idx_q == fpp_pkg::LAST_IDX)
                   || (state_q == fpp_pkg::ST_ERASE)
                   || (state_q == fpp_pkg::ST_READ));

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_q <= fpp_pkg::ST_IDLE;
        end else begin
            unique case (state_q)
                fpp_pkg::ST_IDLE: begin
                    if (wstart_q && mode_q == fpp_pkg::MODE_ERASE) begin
                        state_q <= fpp_pkg::ST_ERASE;
                    end else if (wstart_q) begin
                        state_q <= fpp_pkg::ST_WRITE;
                    end else if (rstart_q) begin
                        state_q <= fpp_pkg::ST_READ;
                    end else if (bufClear_q) begin
                        state_q <= fpp_pkg::ST_CLEAR;
                    end
                end
                fpp_pkg::ST_WRITE,
                fpp_pkg::ST_ERASE,
                fpp_pkg::ST_READ: begin
                    if (opDone) begin
                        state_q <= fpp_pkg::ST_IDLE;
                    end
                end
                fpp_pkg::ST_CLEAR: begin
                    state_q <= fpp_pkg::ST_IDLE;
                end
                default: state_q <= fpp_pkg::ST_IDLE;
            endcase
        end
    end

    // the whole buffer is streamed out one word per acknowledge
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            idx_q <= fpp_pkg::FIRST_IDX;
        end else if (state_q != fpp_pkg::ST_WRITE) begin
            idx_q <= fpp_pkg::FIRST_IDX;
        end else if (flashAck) begin
            idx_q <= idx_q + 1'b1;
        end
    end

    always_comb begin
        flashReq       = '0;
        flashReq.req   = (state_q == fpp_pkg::ST_WRITE) || (state_q == fpp_pkg::ST_ERASE)
                         || (state_q == fpp_pkg::ST_READ);
        flashReq.cmd   = fpp_pkg::CMD_READ_WORD;
        flashReq.addr  = addr_q;
        flashReq.wdata = bufWord;
        if (state_q == fpp_pkg::ST_WRITE) begin
            flashReq.cmd  = fpp_pkg::CMD_WRITE_WORD;
            flashReq.addr = {addr_q[15:7], idx_q};
        end else if (state_q == fpp_pkg::ST_ERASE) begin
            flashReq.cmd  = fpp_pkg::CMD_ERASE_PAGE;
            flashReq.addr = pageBase;
        end
    end

    // held from the accepted start until the operation completes
    assign cpuStall = wstart_q || rstart_q;

    ////////////////////////////////////////////////////////////////////////////
    // read port

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            regRdata_q <= '0;
        end else if (regRead) begin
            unique case (regAddr)
                fpp_pkg::OFS_CTRL:   regRdata_q <= {enabled_q, mode_q, trigger_q,
                                                    wstart_q, rden_q, rstart_q};
                fpp_pkg::OFS_BUFCTL: regRdata_q <= {7'h00, bufClear_q};
                fpp_pkg::OFS_ADDRL:  regRdata_q <= addr_q[7:0];
                fpp_pkg::OFS_ADDRH:  regRdata_q <= addr_q[15:8];
                fpp_pkg::OFS_DATAL:  regRdata_q <= dataLow_q;
                fpp_pkg::OFS_DATAH:  regRdata_q <= dataHigh_q;
                default:             regRdata_q <= 8'h00;
            endcase
        end else begin
            regRdata_q <= 8'h00;
        end
    end

    assign regRdata = regRdata_q;

endmodule
`default_nettype wire

// ===== test/fpp_page_programmer_props.sv
// port assertions of the flash page programmer
`timescale 1ns/1ps
`default_nettype none
module fpp_page_programmer_props (
    input wire logic                       clk_sys,
    input wire logic                       reset,
    input wire logic [fpp_pkg::REG_AW-1:0] regAddr,
    input wire logic [7:0]                 regWdata,
    input wire logic                       regWrite,
    input wire logic                       regRead,
    input wire logic [7:0]                 regRdata,
    input wire logic                       cpuStall,
    input wire fpp_pkg::fpp_flash_req_type flashReq,
    input wire logic                       flashAck,
    input wire logic [fpp_pkg::WORD_W-1:0] flashRdata
);
    default clocking dcb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    logic ackWr;
    assign ackWr = flashReq.req && flashAck && flashReq.cmd == fpp_pkg::CMD_WRITE_WORD;
    ////////////////////////////////////////////////////////////////////////////////
    a_req_means_stall: assert property (flashReq.req |-> cpuStall)
        else $error("flash request without processor hold");
    a_stall_brings_req: assert property ($rose(cpuStall) |=> flashReq.req)
        else $error("hold raised but no flash request");
    a_start_from_sw: assert property ($rose(cpuStall) |-> $past(regWrite)
        && $past(regAddr) == fpp_pkg::OFS_CTRL)
        else $error("operation started without a control write");
    a_req_holds: assert property (flashReq.req && !flashAck |=> flashReq.req
        && $stable(flashReq.addr) && $stable(flashReq.cmd))
        else $error("request changed before acknowledge");
    a_write_index_step: assert property (ackWr && flashReq.addr[6:0] != fpp_pkg::LAST_IDX
        |=> flashReq.req && flashReq.addr == $past(flashReq.addr) + 16'h0001)
        else $error("page write index did not advance");
    a_write_done: assert property (ackWr && flashReq.addr[6:0] == fpp_pkg::LAST_IDX
        |=> !flashReq.req && !cpuStall)
        else $error("page write did not end after last word");
    a_single_word_ops: assert property (flashReq.req && flashAck
        && flashReq.cmd != fpp_pkg::CMD_WRITE_WORD |=> !flashReq.req && !cpuStall)
        else $error("erase or read did not end after one acknowledge");
    a_erase_page_base: assert property (flashReq.req && flashReq.cmd == fpp_pkg::CMD_ERASE_PAGE
        |-> flashReq.addr[6:0] == fpp_pkg::FIRST_IDX
        && flashReq.addr[15:8] <= fpp_pkg::MAX_PAGE_HI)
        else $error("erase address not a valid page base");
    a_write_from_zero: assert property ($rose(flashReq.req)
        && flashReq.cmd == fpp_pkg::CMD_WRITE_WORD
        |-> flashReq.addr[6:0] == fpp_pkg::FIRST_IDX)
        else $error("page write not starting at first word");
endmodule
bind fpp_page_programmer fpp_page_programmer_props u_props (
    .clk_sys(clk_sys), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .cpuStall(cpuStall),
    .flashReq(flashReq), .flashAck(flashAck), .flashRdata(flashRdata)
);
`default_nettype wire

// ===== test/tb_fpp_page_programmer.sv
// self-checking bench of the flash page programmer
`timescale 1ns/1ps
`default_nettype none
module tb_fpp_page_programmer;
    logic                       clk_sys = 1'b0;
    logic                       reset = 1'b1;
    logic [3:0]                 regAddr = 4'h0;
    logic [7:0]                 regWdata = 8'h00;
    logic                       regWrite = 1'b0;
    logic                       regRead = 1'b0;
    logic [7:0]                 regRdata;
    logic                       cpuStall;
    fpp_pkg::fpp_flash_req_type flashReq;
    logic                       flashAck = 1'b0;
    logic [15:0]                flashRdata = 16'h0000;
    logic [15:0]                keys [3];
    int                         fails = 0;
    int                         samplesChecked = 0;
    int                         cycles = 0;
    always #12.5 clk_sys = ~clk_sys;
    fpp_page_programmer u_dut (
        .clk_sys(clk_sys), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .cpuStall(cpuStall),
        .flashReq(flashReq), .flashAck(flashAck), .flashRdata(flashRdata)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (fails == 0 && samplesChecked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // the whole run takes about 1450 cycles
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            fails = fails + 1;
            end_of_test();
        end
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        samplesChecked++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regWrite <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask
    // outputs sampled at an edge show the cycle before it, never a race with the flops
    task automatic rdc(input logic [3:0] a, input logic [7:0] e, input string nm);
        @(posedge clk_sys);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRead <= 1'b0;
        @(posedge clk_sys);
        chk(nm, {8'h00, e}, {8'h00, regRdata});
    endtask
    function automatic logic [15:0] pat(input int k);
        pat = {k[7:0], k[7:0] ^ 8'h5a};
    endfunction
    task automatic ld(input int k);
        logic [15:0] v;
        v = pat(k);
        wr(fpp_pkg::OFS_DATAL, v[7:0]);
        wr(fpp_pkg::OFS_DATAH, v[15:8]);
    endtask
    // acts as the flash array: acknowledges each request one cycle after seeing it
    task automatic serve(input int n, input fpp_pkg::fpp_cmd_type c, input logic [15:0] a0,
                         input bit full);
        int w;
        for (int i = 0; i < n; i++) begin
            w = 0;
            do begin
                @(posedge clk_sys);
                w++;
            end while (flashReq.req !== 1'b1 && w < 50);
            chk("req", 16'h0001, {15'h0000, flashReq.req});
            chk("stall", 16'h0001, {15'h0000, cpuStall});
            chk("cmd", {14'h0000, c}, {14'h0000, flashReq.cmd});
            chk("addr", a0 + 16'(i), flashReq.addr);
            if (c == fpp_pkg::CMD_WRITE_WORD) begin
                chk("wdata", full ? pat(i == 127 ? 128 : i) : 16'h0000, flashReq.wdata);
            end
            flashAck <= 1'b1;
            @(posedge clk_sys);
            flashAck <= 1'b0;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        keys = '{fpp_pkg::KEY1_VALUE, fpp_pkg::KEY2_VALUE, fpp_pkg::KEY3_VALUE};
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        rdc(fpp_pkg::OFS_CTRL, 8'h00, "ctrl reset");
        wr(fpp_pkg::OFS_CTRL, 8'h80);
        rdc(fpp_pkg::OFS_CTRL, 8'h00, "ctrl set enabled");
        wr(fpp_pkg::OFS_ADDRL, 8'h05);
        ld(0);
        rdc(fpp_pkg::OFS_ADDRL, 8'h05, "addrl disabled load");
        wr(fpp_pkg::OFS_CTRL, 8'h68);
        for (int k = 0; k < 3; k++) begin
            wr(fpp_pkg::OFS_KEY1L + 4'(2 * k), keys[k][7:0]);
            wr(fpp_pkg::OFS_KEY1H + 4'(2 * k), keys[k][15:8]);
        end
        rdc(fpp_pkg::OFS_CTRL, 8'he0, "ctrl enabled");
        wr(fpp_pkg::OFS_CTRL, 8'ha4);
        rdc(fpp_pkg::OFS_CTRL, 8'ha0, "ctrl reserved mode");
        wr(fpp_pkg::OFS_ADDRH, 8'h01);
        wr(fpp_pkg::OFS_ADDRL, 8'h80);
        ld(0);
        ld(1);
        rdc(fpp_pkg::OFS_ADDRL, 8'h82, "addrl increment");
        wr(fpp_pkg::OFS_BUFCTL, 8'h01);
        repeat (4) @(posedge clk_sys);
        rdc(fpp_pkg::OFS_BUFCTL, 8'h00, "buffer clear bit");
        wr(fpp_pkg::OFS_CTRL, 8'h84);
        serve(128, fpp_pkg::CMD_WRITE_WORD, 16'h0180, 1'b0);
        rdc(fpp_pkg::OFS_CTRL, 8'h80, "ctrl write done");
        wr(fpp_pkg::OFS_ADDRL, 8'h80);
        for (int k = 0; k < 129; k++) begin
            ld(k);
        end
        rdc(fpp_pkg::OFS_ADDRL, 8'hff, "addrl page end");
        wr(fpp_pkg::OFS_CTRL, 8'h84);
        serve(128, fpp_pkg::CMD_WRITE_WORD, 16'h0180, 1'b1);
        wr(fpp_pkg::OFS_CTRL, 8'h84);
        serve(128, fpp_pkg::CMD_WRITE_WORD, 16'h0180, 1'b0);
        wr(fpp_pkg::OFS_ADDRH, 8'hbf);
        wr(fpp_pkg::OFS_ADDRL, 8'ha5);
        wr(fpp_pkg::OFS_CTRL, 8'h94);
        serve(1, fpp_pkg::CMD_ERASE_PAGE, 16'hbf80, 1'b0);
        rdc(fpp_pkg::OFS_CTRL, 8'h90, "ctrl erase done");
        rdc(fpp_pkg::OFS_ADDRL, 8'ha5, "addrl after erase");
        wr(fpp_pkg::OFS_ADDRH, 8'hc0);
        wr(fpp_pkg::OFS_CTRL, 8'h94);
        rdc(fpp_pkg::OFS_CTRL, 8'h90, "ctrl page range");
        wr(fpp_pkg::OFS_ADDRH, 8'hbf);
        flashRdata <= 16'hbeef;
        wr(fpp_pkg::OFS_CTRL, 8'hb1);
        rdc(fpp_pkg::OFS_CTRL, 8'hb0, "ctrl read no enable");
        wr(fpp_pkg::OFS_CTRL, 8'hb3);
        serve(1, fpp_pkg::CMD_READ_WORD, 16'hbfa5, 1'b0);
        rdc(fpp_pkg::OFS_CTRL, 8'hb2, "ctrl read done");
        rdc(fpp_pkg::OFS_DATAL, 8'hef, "datal read");
        rdc(fpp_pkg::OFS_DATAH, 8'hbe, "datah read");
        wr(fpp_pkg::OFS_CTRL, 8'h00);
        rdc(fpp_pkg::OFS_CTRL, 8'h00, "ctrl disabled");
        wr(fpp_pkg::OFS_ADDRL, 8'h10);
        ld(3);
        rdc(fpp_pkg::OFS_ADDRL, 8'h10, "addrl no load");
        wr(fpp_pkg::OFS_CTRL, 8'h04);
        rdc(fpp_pkg::OFS_CTRL, 8'h00, "ctrl write refused");
        wr(4'hd, 8'h55);
        rdc(4'hd, 8'h00, "unmapped");
        end_of_test();
    end
endmodule
`default_nettype wire
